// ---- serial_tx_pkg.sv ----
// Function
// - Unused lanes power down only while both lane shutdown bits are set; either bit alone changes nothing.
// - Active lane shutdown powers down lanes a0, a3, b0 and b3, and only in link configurations 4244, 2242, 2441, 4211 and 2221.
// - A powered-down lane stops driving and leaves its output buffer in high impedance.
// - With the overrange routing bit at one, channel A's fast over-range flag appears on the power-down pin; at zero the pin works normally.
// - The over-range routing works only while the overrange pin enable bit (bit 3 of the amplitude register) is one.
// - The three-bit amplitude field in bits 7-5 selects the transmitter swing code for all lanes.
package serial_tx_pkg;

  typedef enum logic [2:0] {
    CFG_4244,
    CFG_2242,
    CFG_2441,
    CFG_4211,
    CFG_2221,
    CFG_OTHER
  } link_cfg_t;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int LANES = 8;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_LANE = 8'h17;
  localparam logic [7:0] IDX_ROUTE = 8'h1a;
  localparam logic [7:0] IDX_SWING = 8'h1b;
  localparam logic [7:0] IDX_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_LANE = {IDX_LANE[5:0], 2'b00};
  localparam logic [7:0] ADDR_ROUTE = {IDX_ROUTE[5:0], 2'b00};
  localparam logic [7:0] ADDR_SWING = {IDX_SWING[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] LANE_WMASK = 8'h68;
  localparam logic [7:0] ROUTE_WMASK = 8'h02;
  localparam logic [7:0] SWING_WMASK = 8'he8;

  localparam int PLL_RST_BIT = 6;
  localparam int SHUT_HI_BIT = 5;
  localparam int SHUT_LO_BIT = 3;
  localparam int ROUTE_A_BIT = 1;
  localparam int PIN_EN_BIT = 3;
  localparam int SWING_LSB = 5;
  localparam int SWING_MSB = 7;

  localparam int ST_SHUT_BIT = 0;
  localparam int ST_PIN_BIT = 1;
  localparam int ST_ROUTE_BIT = 2;

  // Lanes [3:0] are a0..a3 and [7:4] are b0..b3; set bits mark a0, a3, b0, b3.
  localparam logic [7:0] LANE_UNUSED_MASK = 8'h99;
  localparam logic [7:0] LANE_ALL_ON = 8'hff;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : serial_tx_pkg

// ---- pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic level
);

  logic stage1;
  logic stage2;
  logic stage3;

  // The level moves only once the second and third stages agree.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
      begin
        level <= stage3;
      end
    end
  end

endmodule : pin_sync

// ---- lane_power_ctrl.sv ----
`timescale 1ns/100ps
module lane_power_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic laneShutdownHi,
  input wire logic laneShutdownLo,
  input wire serial_tx_pkg::link_cfg_t linkCfg,
  output logic [serial_tx_pkg::LANES-1:0] laneOe
);

  wire cfgApplies;
  wire shutActive;

  assign cfgApplies = (linkCfg == serial_tx_pkg::CFG_4244) ||
                      (linkCfg == serial_tx_pkg::CFG_2242) ||
                      (linkCfg == serial_tx_pkg::CFG_2441) ||
                      (linkCfg == serial_tx_pkg::CFG_4211) ||
                      (linkCfg == serial_tx_pkg::CFG_2221);
  // Both bits must be set; this keeps a half-written update from dropping lanes.
  assign shutActive = laneShutdownHi && laneShutdownLo && cfgApplies;

  genvar i;
  generate
    for (i = 0; i < serial_tx_pkg::LANES; i++)
    begin : gLane
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          laneOe[i] <= serial_tx_pkg::LANE_ALL_ON[i];
        end
        else
        begin
          // A low enable releases the buffer to high impedance.
          laneOe[i] <= !(shutActive && serial_tx_pkg::LANE_UNUSED_MASK[i]);
        end
      end
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_lane_both_bits: assert property (
    $past(rst_n) && $past(laneShutdownHi ^ laneShutdownLo)
    |-> laneOe == serial_tx_pkg::LANE_ALL_ON)
    else $error("single shutdown bit changed lanes");
  a_lane_unused_off: assert property (
    $past(rst_n) && $past(shutActive) |-> laneOe == ~serial_tx_pkg::LANE_UNUSED_MASK)
    else $error("unused lanes not powered down");
  a_lane_cfg_gate: assert property (
    $past(rst_n) && $past(!cfgApplies) |-> laneOe == serial_tx_pkg::LANE_ALL_ON)
    else $error("lanes shut in unsupported configuration");
  a_lane_used_on: assert property (
    (laneOe & ~serial_tx_pkg::LANE_UNUSED_MASK) == ~serial_tx_pkg::LANE_UNUSED_MASK)
    else $error("used lane released");
  c_lane_shutdown: cover property (laneOe == ~serial_tx_pkg::LANE_UNUSED_MASK);

endmodule : lane_power_ctrl

// ---- serial_tx_lane_and_overrange_ctrl.sv ----
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
module serial_tx_lane_and_overrange_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [serial_tx_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [serial_tx_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [serial_tx_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [serial_tx_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire serial_tx_pkg::link_cfg_t linkCfg,
  input wire logic fastOverrangeFlag,
  input wire logic powerdownPinIn,
  output logic powerdownPinOut,
  output logic powerdownPinOe,
  output logic powerdownRequest,
  output logic pllReset,
  output logic [2:0] serialOutputAmplitude,
  output logic [serial_tx_pkg::LANES-1:0] laneOe
);

  logic [7:0] lanePowerPllCtrl;
  logic [7:0] overrangeRouteCtrl;
  logic [7:0] outputSwingOverrangeEn;
  logic awHeld;
  logic wHeld;
  logic [serial_tx_pkg::ADDR_W-1:0] wrAddr;
  logic [7:0] wrByte;
  logic wrLaneOk;
  logic pinLevel;

  wire lane_shutdown_hi;
  wire lane_shutdown_lo;
  wire overrange_route_a;
  wire overrange_pin_enable;
  wire routeActive;
  wire commit;
  wire hitLane;
  wire hitRoute;
  wire hitSwing;
  wire wrHitAny;
  wire rdHitLane;
  wire rdHitRoute;
  wire rdHitSwing;
  wire rdHitStatus;
  wire rdHitAny;
  wire [7:0] statusByte;
  wire [7:0] rdByte;
  wire [7:0] next_lane;
  wire [7:0] next_route;
  wire [7:0] next_swing;

  assign lane_shutdown_hi = lanePowerPllCtrl[serial_tx_pkg::SHUT_HI_BIT];
  assign lane_shutdown_lo = lanePowerPllCtrl[serial_tx_pkg::SHUT_LO_BIT];
  assign overrange_route_a = overrangeRouteCtrl[serial_tx_pkg::ROUTE_A_BIT];
  assign overrange_pin_enable = outputSwingOverrangeEn[serial_tx_pkg::PIN_EN_BIT];
  assign routeActive = overrange_route_a && overrange_pin_enable;

  // Write decode; reserved bits are masked so they always read zero.
  assign commit = awHeld && wHeld && !s_axi_bvalid;
  assign hitLane = (wrAddr == serial_tx_pkg::ADDR_LANE);
  assign hitRoute = (wrAddr == serial_tx_pkg::ADDR_ROUTE);
  assign hitSwing = (wrAddr == serial_tx_pkg::ADDR_SWING);
  assign wrHitAny = hitLane || hitRoute || hitSwing;
  assign next_lane = wrByte & serial_tx_pkg::LANE_WMASK;
  assign next_route = wrByte & serial_tx_pkg::ROUTE_WMASK;
  assign next_swing = wrByte & serial_tx_pkg::SWING_WMASK;

  // Read decode, answered straight from the stored bytes, or for status from the live pin and lane state.
  assign rdHitLane = (s_axi_araddr == serial_tx_pkg::ADDR_LANE);
  assign rdHitRoute = (s_axi_araddr == serial_tx_pkg::ADDR_ROUTE);
  assign rdHitSwing = (s_axi_araddr == serial_tx_pkg::ADDR_SWING);
  assign rdHitStatus = (s_axi_araddr == serial_tx_pkg::ADDR_STATUS);
  assign rdHitAny = rdHitLane || rdHitRoute || rdHitSwing || rdHitStatus;
  assign statusByte = {5'h00, powerdownPinOe, pinLevel, !laneOe[0]};
  assign rdByte = rdHitLane ? lanePowerPllCtrl :
                  rdHitRoute ? overrangeRouteCtrl :
                  rdHitSwing ? outputSwingOverrangeEn :
                  rdHitStatus ? statusByte : serial_tx_pkg::REG_RESET;

  // Address and data are taken in either order. Each ready stays low until the response has
  // gone, so a second write can never overtake the one still being answered.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      awHeld <= 1'b0;
      wrAddr <= '0;
    end
    else if (s_axi_awready && s_axi_awvalid)
    begin
      awHeld <= 1'b1;
      wrAddr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (commit)
    begin
      awHeld <= 1'b0;
    end
    else if (!awHeld && !s_axi_bvalid)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_wready <= 1'b0;
      wHeld <= 1'b0;
      wrByte <= serial_tx_pkg::REG_RESET;
      wrLaneOk <= 1'b0;
    end
    else if (s_axi_wready && s_axi_wvalid)
    begin
      wHeld <= 1'b1;
      wrByte <= s_axi_wdata[7:0];
      wrLaneOk <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end
    else if (commit)
    begin
      wHeld <= 1'b0;
    end
    else if (!wHeld && !s_axi_bvalid)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= serial_tx_pkg::RESP_OKAY;
    end
    else if (commit)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHitAny ? serial_tx_pkg::RESP_OKAY : serial_tx_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // A write with byte lane 0 off is acknowledged but stores nothing.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lanePowerPllCtrl <= serial_tx_pkg::REG_RESET;
      overrangeRouteCtrl <= serial_tx_pkg::REG_RESET;
      outputSwingOverrangeEn <= serial_tx_pkg::REG_RESET;
    end
    else if (commit && wrLaneOk)
    begin
      if (hitLane)
      begin
        lanePowerPllCtrl <= next_lane;
      end
      if (hitRoute)
      begin
        overrangeRouteCtrl <= next_route;
      end
      if (hitSwing)
      begin
        outputSwingOverrangeEn <= next_swing;
      end
    end
  end

  // Only one read is open at a time: arready returns one edge after the answer is taken.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= serial_tx_pkg::RESP_OKAY;
    end
    else if (s_axi_arready && s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rdByte};
      s_axi_rresp <= rdHitAny ? serial_tx_pkg::RESP_OKAY : serial_tx_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
    else if (!s_axi_rvalid)
    begin
      s_axi_arready <= 1'b1;
    end
  end

  // The pin is only sampled for its own powerdown meaning while nobody overwrites it.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      powerdownPinOe <= 1'b0;
      powerdownPinOut <= 1'b0;
      powerdownRequest <= 1'b0;
      pllReset <= 1'b0;
      serialOutputAmplitude <= 3'h0;
    end
    else
    begin
      powerdownPinOe <= routeActive;
      powerdownPinOut <= routeActive && fastOverrangeFlag;
      powerdownRequest <= !routeActive && pinLevel;
      // The PLL is held in restart while the bit is one; software makes the pulse.
      pllReset <= lanePowerPllCtrl[serial_tx_pkg::PLL_RST_BIT];
      serialOutputAmplitude <=
        outputSwingOverrangeEn[serial_tx_pkg::SWING_MSB:serial_tx_pkg::SWING_LSB];
    end
  end

  // The request ignores the pin while the device drives it, so the flag cannot loop back.
  pin_sync uPinSync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(powerdownPinIn),
    .level(pinLevel)
  );

  lane_power_ctrl uLanes (
    .clk(clk),
    .rst_n(rst_n),
    .laneShutdownHi(lane_shutdown_hi),
    .laneShutdownLo(lane_shutdown_lo),
    .linkCfg(linkCfg),
    .laneOe(laneOe)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Checks that look back skip the first edge after reset, where the past is still reset.
  a_route_needs_enable: assert property (
    $past(rst_n) && $past(!overrange_pin_enable) |-> !powerdownPinOe)
    else $error("pin overwritten without enable");
  a_route_drives_pin: assert property (
    $past(rst_n) && $past(routeActive)
    |-> powerdownPinOe && (powerdownPinOut == $past(fastOverrangeFlag)))
    else $error("overrange flag not on pin");
  a_route_off_normal: assert property (
    $past(rst_n) && $past(!overrange_route_a) |-> !powerdownPinOe && !powerdownPinOut)
    else $error("pin driven with routing off");
  a_route_blocks_req: assert property (
    $past(rst_n) && $past(routeActive) |-> !powerdownRequest)
    else $error("powerdown request passed while pin overwritten");
  a_swing_follows: assert property (
    commit && wrLaneOk && hitSwing
    |=> ##1 serialOutputAmplitude ==
      $past(wrByte[serial_tx_pkg::SWING_MSB:serial_tx_pkg::SWING_LSB], 2))
    else $error("amplitude code not applied");
  a_swing_tracks: assert property (
    $past(rst_n)
    |-> serialOutputAmplitude ==
      $past(outputSwingOverrangeEn[serial_tx_pkg::SWING_MSB:serial_tx_pkg::SWING_LSB]))
    else $error("amplitude code differs from register");
  a_pll_follow: assert property (
    $past(rst_n) |-> pllReset == $past(lanePowerPllCtrl[serial_tx_pkg::PLL_RST_BIT]))
    else $error("pll restart not driven");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  a_read_refused: assert property (
    s_axi_arvalid && s_axi_arready && !rdHitAny
    |=> s_axi_rresp == serial_tx_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_write_refused: assert property (
    commit && !wrHitAny |=> s_axi_bvalid && s_axi_bresp == serial_tx_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  a_reserved_zero: assert property (
    (lanePowerPllCtrl & ~serial_tx_pkg::LANE_WMASK) == 8'h00 &&
    (overrangeRouteCtrl & ~serial_tx_pkg::ROUTE_WMASK) == 8'h00 &&
    (outputSwingOverrangeEn & ~serial_tx_pkg::SWING_WMASK) == 8'h00)
    else $error("reserved bit stored");
  // The covers show that each main scenario is reached at least once.
  c_route_on: cover property (powerdownPinOe && powerdownPinOut);
  c_pll_pulse: cover property (!pllReset ##1 pllReset ##[1:20] !pllReset);
  c_write_then_read: cover property (s_axi_bvalid ##[1:10] s_axi_rvalid);
  c_write_refused: cover property (s_axi_bvalid && s_axi_bresp == serial_tx_pkg::RESP_SLVERR);

endmodule : serial_tx_lane_and_overrange_ctrl

// ---- serial_tx_lane_and_overrange_ctrl_tb.sv ----
`timescale 1ns/100ps
module serial_tx_lane_and_overrange_ctrl_tb;
  logic clk;
  logic rst_n;
  logic [7:0] awAddr;
  logic awValid;
  logic awReady;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wValid;
  logic wReady;
  logic [1:0] bResp;
  logic bValid;
  logic bReady;
  logic [7:0] arAddr;
  logic arValid;
  logic arReady;
  logic [31:0] rData;
  logic [1:0] rResp;
  logic rValid;
  logic rReady;
  serial_tx_pkg::link_cfg_t linkCfg;
  logic fastFlag;
  logic pinIn;
  logic pinOut;
  logic pinOe;
  logic pdReq;
  logic pllReset;
  logic [2:0] amplitude;
  logic [7:0] laneOe;
  logic [33:0] rdQ[$];
  logic [1:0] wrQ[$];
  logic [33:0] note;
  integer seed;
  int errors;
  int cmpCount;

  serial_tx_lane_and_overrange_ctrl DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .linkCfg(linkCfg), .fastOverrangeFlag(fastFlag),
    .powerdownPinIn(pinIn), .powerdownPinOut(pinOut), .powerdownPinOe(pinOe),
    .powerdownRequest(pdReq), .pllReset(pllReset), .serialOutputAmplitude(amplitude),
    .laneOe(laneOe));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wrapUp;
    $display("Comparisons %0d, mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrapUp

  // Both channels are offered together and each is released at its own take.
  task automatic axiWrite(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
    input logic [1:0] er);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    wrQ.push_back(er);
    awAddr <= a;
    wData <= {24'h000000, d};
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    while (!(awDone && wDone))
    begin
      @(posedge clk);
      if (!awDone && awReady)
      begin
        awDone = 1'b1;
        awValid <= 1'b0;
      end
      if (!wDone && wReady)
      begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
    end
    do @(posedge clk); while (bValid !== 1'b1);
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    rdQ.push_back({er, 24'h000000, ed});
    arAddr <= a;
    arValid <= 1'b1;
    do @(posedge clk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge clk); while (rValid !== 1'b1);
  endtask : axiRead

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // Results are judged where they appear, against the oldest note of the driver.
  always @(posedge clk)
  begin
    if (rst_n && rValid && rReady)
    begin
      note = (rdQ.size() > 0) ? rdQ.pop_front() : 34'h3ffffffff;
      check("rdata", rData, note[31:0]);
      check("rresp", {30'h0, rResp}, {30'h0, note[33:32]});
    end
    if (rst_n && bValid && bReady)
    begin
      note[1:0] = (wrQ.size() > 0) ? wrQ.pop_front() : 2'b11;
      check("bresp", {30'h0, bResp}, {30'h0, note[1:0]});
    end
  end

  initial
  begin
    #200000;
    errors++;
    wrapUp();
  end

  initial
  begin
    logic [7:0] d;
    logic b;
    seed = 32'h4cd0;
    errors = 0;
    cmpCount = 0;
    rst_n = 1'b0;
    awAddr = 8'h00;
    awValid = 1'b0;
    wData = 32'h0;
    wStrb = 4'h1;
    wValid = 1'b0;
    bReady = 1'b1;
    arAddr = 8'h00;
    arValid = 1'b0;
    rReady = 1'b1;
    linkCfg = serial_tx_pkg::CFG_4244;
    fastFlag = 1'b0;
    pinIn = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axiRead(serial_tx_pkg::ADDR_LANE, 8'h00, serial_tx_pkg::RESP_OKAY);
    axiRead(serial_tx_pkg::ADDR_ROUTE, 8'h00, serial_tx_pkg::RESP_OKAY);
    axiRead(serial_tx_pkg::ADDR_SWING, 8'h00, serial_tx_pkg::RESP_OKAY);
    axiRead(8'h00, 8'h00, serial_tx_pkg::RESP_SLVERR);
    settle(1);
    check("laneOe", {24'h0, laneOe}, 32'hff);
    check("pllReset", {31'h0, pllReset}, 32'h0);
    axiWrite(serial_tx_pkg::ADDR_LANE, 8'h40, 4'h1, serial_tx_pkg::RESP_OKAY);
    settle(2);
    check("pllReset", {31'h0, pllReset}, 32'h1);
    axiWrite(serial_tx_pkg::ADDR_LANE, 8'h00, 4'h1, serial_tx_pkg::RESP_OKAY);
    settle(2);
    check("pllReset", {31'h0, pllReset}, 32'h0);
    // Every link configuration meets every combination of the two shutdown bits.
    for (int c = 0; c < 6; c++)
    begin
      linkCfg <= serial_tx_pkg::link_cfg_t'(c);
      for (int k = 0; k < 4; k++)
      begin
        d = {2'b00, k[1], 1'b0, k[0], 3'b000};
        axiWrite(serial_tx_pkg::ADDR_LANE, d, 4'h1, serial_tx_pkg::RESP_OKAY);
        axiRead(serial_tx_pkg::ADDR_LANE, d, serial_tx_pkg::RESP_OKAY);
        settle(2);
        check("laneOe", {24'h0, laneOe}, (k == 3 && c < 5) ? 32'h66 : 32'hff);
      end
    end
    for (int code = 0; code < 8; code++)
    begin
      b = 1'($random(seed));
      d = {code[2:0], 1'b0, b, 3'b000};
      axiWrite(serial_tx_pkg::ADDR_SWING, d, 4'h1, serial_tx_pkg::RESP_OKAY);
      axiRead(serial_tx_pkg::ADDR_SWING, d, serial_tx_pkg::RESP_OKAY);
      settle(2);
      check("amplitude", {29'h0, amplitude}, code);
    end
    pinIn <= 1'b1;
    axiWrite(serial_tx_pkg::ADDR_ROUTE, 8'h02, 4'h1, serial_tx_pkg::RESP_OKAY);
    axiWrite(serial_tx_pkg::ADDR_SWING, 8'h00, 4'h1, serial_tx_pkg::RESP_OKAY);
    settle(8);
    check("pinOe", {31'h0, pinOe}, 32'h0);
    check("pdReq", {31'h0, pdReq}, 32'h1);
    axiWrite(serial_tx_pkg::ADDR_SWING, 8'h08, 4'h1, serial_tx_pkg::RESP_OKAY);
    settle(2);
    check("pinOe", {31'h0, pinOe}, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      b = 1'($random(seed));
      fastFlag <= b;
      settle(3);
      check("pinOut", {31'h0, pinOut}, {31'h0, b});
      check("pdReq", {31'h0, pdReq}, 32'h0);
    end
    axiWrite(serial_tx_pkg::ADDR_ROUTE, 8'h00, 4'h1, serial_tx_pkg::RESP_OKAY);
    settle(8);
    check("pinOe", {31'h0, pinOe}, 32'h0);
    check("pdReq", {31'h0, pdReq}, 32'h1);
    // Refused writes and a write with byte lane 0 off must leave the routing register untouched.
    axiWrite(8'h00, 8'h02, 4'h1, serial_tx_pkg::RESP_SLVERR);
    axiWrite(serial_tx_pkg::ADDR_STATUS, 8'h07, 4'h1, serial_tx_pkg::RESP_SLVERR);
    axiWrite(serial_tx_pkg::ADDR_ROUTE + 8'h01, 8'h02, 4'h1, serial_tx_pkg::RESP_SLVERR);
    axiWrite(serial_tx_pkg::ADDR_ROUTE, 8'h02, 4'h0, serial_tx_pkg::RESP_OKAY);
    axiRead(serial_tx_pkg::ADDR_ROUTE, 8'h00, serial_tx_pkg::RESP_OKAY);
    // Status: no shutdown in the last configuration, filtered pin high, pin not overwritten.
    axiRead(serial_tx_pkg::ADDR_STATUS, 8'h02, serial_tx_pkg::RESP_OKAY);
    // A second reset must clear registers that now hold non-zero values.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axiRead(serial_tx_pkg::ADDR_SWING, 8'h00, serial_tx_pkg::RESP_OKAY);
    axiRead(serial_tx_pkg::ADDR_LANE, 8'h00, serial_tx_pkg::RESP_OKAY);
    settle(4);
    wrapUp();
  end
endmodule : serial_tx_lane_and_overrange_ctrl_tb
